/* File: core/csp_port.sv */
// serial host port of a sigma-delta converter: link shifter on the
// serial clock, register file and data-ready on the core clock
// assumes the host masters cs_n, sclk and din; edge_polarity_strap is static
`timescale 1ns/1ps

// Functional notes
// - after reset the first transfer is taken as a communications write
// - communications byte selects read or write and the target register
// - access code 01 reads the selected register once
// - access code 10 enters continuous read of the selected register
// - continuous read keeps sampling din; code 11 leaves it
// - written bits reach the register only after its full length
// - strap high captures on rising sclk, strap low on falling
// - strap high launches on falling sclk, strap low on rising
// - selected register is copied whole into the output word at read start
// - framed read shows the msb on dout from the falling cs_n
// - later read bits launch on the non-active sclk edge
// - ready asserts low when a new word lands in the data register
// - ready deasserts on data read completion and before each refresh
// - the same data word may be read again after ready deasserts
// - after any register write the port expects a communications byte
// - register lengths are 8, 16 or 24 bits by address
// - while reset is low the port ignores traffic and ready stays high
module csp_port
  import csp_pkg::*;
(
  // core clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // serial link
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic din,
  output logic dout,
  output logic dout_oe,
  output logic rdy_n,
  // strap
  input wire logic edge_polarity_strap,
  // converter side
  input wire logic conv_valid,
  input wire logic [23:0] conv_data,
  input wire logic [6:0] status_in,
  output logic [NREG*REG_W-1:0] reg_image,
  output logic reg_written,
  output logic [2:0] reg_written_addr
);

  // link domain state
  csp_state_t st;
  csp_state_t next_st;
  logic [4:0] cnt;
  logic [4:0] next_cnt;
  logic [23:0] in_sr;
  logic [2:0] sel_addr;
  logic [2:0] next_sel;
  logic [23:0] rd_word;
  logic word_id;
  csp_wr_t wr_hold;
  csp_evt_t evt;
  logic load_rd;
  logic post_wr;
  logic post_rd;
  // launch-edge copies of the bit count and word identity; dout picks its bit with these and word_id
  logic [4:0] lcnt;
  logic lword;

  // core domain state
  logic [REG_W-1:0] reg_flat [NREG];
  logic [23:0] data_reg;
  logic [7:0] status_q;
  csp_evt_t evt_s;
  csp_evt_t evt_d;

  // capture edge follows the strap; the strap is a static pin so the
  // selection never switches while the link runs
  // hazard: a strap change with the link active would glitch the capture clock
  wire cap_clk = edge_polarity_strap ? sclk : ~sclk;

  // decode of the incoming bit stream
  // the command byte is decoded from shift_in so it acts at its eighth capture
  wire [23:0] shift_in = {in_sr[22:0], din};
  wire [4:0] cnt_inc = cnt + 5'h01;
  wire [7:0] comm_byte = shift_in[7:0];
  wire [1:0] acc = comm_byte[COMM_RW_HI_POS:COMM_RW_LO_POS];
  wire [2:0] comm_addr = comm_byte[COMM_ADDR_LSB +: ADDR_W];
  wire [4:0] cur_len = csp_reg_len(sel_addr);
  wire word_done = (cnt_inc == cur_len);
  wire comm_done = (cnt_inc == COMM_LEN);
  wire sel_is_data = (sel_addr == ADDR_DATA);

  // parallel copy source for the output word, left aligned to bit 23;
  // reg_flat is quasi-static and the data register is guarded by ready
  // trade-off: no double buffer, so a read must not start inside the ready guard
  wire [2:0] load_addr = (st == ST_COMM) ? comm_addr : sel_addr;
  wire [4:0] load_len = csp_reg_len(load_addr);
  wire [23:0] rd_src = reg_flat[load_addr];
  wire [23:0] rd_load_val = rd_src << (LEN_24 - load_len);
  wire [23:0] wr_val = shift_in & csp_len_mask(cur_len);

  // next state of the link sequencer
  // defaults keep counting and hold the state; branches only override them
  always_comb begin
    next_st = st;
    next_cnt = cnt_inc;
    next_sel = sel_addr;
    load_rd = 1'b0;
    post_wr = 1'b0;
    post_rd = 1'b0;
    case (st)
      ST_COMM: begin
        if (comm_done) begin
          next_cnt = CNT_RST_VAL;
          case (acc)
            ACC_WRITE: begin
              next_st = ST_WRITE;
              next_sel = comm_addr;
            end
            ACC_READ: begin
              next_st = ST_READ;
              next_sel = comm_addr;
              load_rd = 1'b1;
            end
            ACC_CONT: begin
              next_st = ST_CONT;
              next_sel = comm_addr;
              load_rd = 1'b1;
            end
            // all ones is a no-op here, so trailing ones after a write
            // leave the port waiting for a communications byte
            default: next_st = ST_COMM;
          endcase
        end
      end
      ST_WRITE: begin
        // a short register keeps its low bits; bits past its length
        // are taken as the next command byte
        if (word_done) begin
          next_cnt = CNT_RST_VAL;
          next_st = ST_COMM;
          post_wr = 1'b1;
        end
      end
      ST_READ: begin
        // din is ignored through the word; only the count moves
        if (word_done) begin
          next_cnt = CNT_RST_VAL;
          next_st = ST_COMM;
          post_rd = sel_is_data;
        end
      end
      ST_CONT: begin
        // din is watched through each word; its first byte may end the mode
        // other codes inside a word are ignored, since din should stay low
        if (comm_done && acc == ACC_EXIT) begin
          next_cnt = CNT_RST_VAL;
          next_st = ST_COMM;
        end else if (word_done) begin
          next_cnt = CNT_RST_VAL;
          load_rd = 1'b1;
          post_rd = sel_is_data;
        end
      end
      default: begin
        // unreachable state: recover to waiting for a command
        next_cnt = CNT_RST_VAL;
        next_st = ST_COMM;
      end
    endcase
  end

  // capture edge: reset holds the link idle and expecting a command
  // cs_n high freezes the sequencer, so one access may span several frames
  always_ff @(posedge cap_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= ST_COMM;
      cnt <= CNT_RST_VAL;
      in_sr <= REG_RST_VAL;
      sel_addr <= ADDR_STATUS;
    end else if (!cs_n) begin
      st <= next_st;
      cnt <= next_cnt;
      in_sr <= shift_in;
      sel_addr <= next_sel;
    end
  end

  // capture edge: output word load and events for the core
  // events are toggles, not pulses: a serial-clock pulse may be shorter or
  // longer than a core period, while a toggle survives either
  always_ff @(posedge cap_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_word <= REG_RST_VAL;
      word_id <= 1'b0;
      wr_hold <= '0;
      evt <= '0;
    end else if (!cs_n) begin
      if (load_rd) begin
        rd_word <= rd_load_val;
        word_id <= ~word_id;
      end
      if (post_wr) begin
        wr_hold <= '{addr: sel_addr, data: wr_val};
        evt.wr_tgl <= ~evt.wr_tgl;
      end
      if (post_rd) begin
        evt.rd_tgl <= ~evt.rd_tgl;
      end
    end
  end

  // launch edge: remember how many bits the host has taken of which word
  // only copies of the capture count and word identity are kept, so dout never follows logic
  // that changes on the capture edge it is sampled on, other than a word load
  always_ff @(negedge cap_clk or negedge rst_n) begin
    if (!rst_n) begin
      lcnt <= CNT_RST_VAL;
      lword <= 1'b0;
    end else if (!cs_n) begin
      lcnt <= cnt;
      lword <= word_id;
    end
  end

  // until a launch edge follows a word load the msb is shown, so a framed
  // read has it from cs_n falling; later bits move only on launch edges
  // limitation: dout is a mux of flops, so it settles a gate delay after
  // cs_n falls or a launch edge arrives
  wire [4:0] out_idx = (lword == word_id) ? lcnt : CNT_RST_VAL;
  wire reading = (st == ST_READ) || (st == ST_CONT);
  assign dout = rd_word[MSB_IDX - out_idx];
  assign dout_oe = ~cs_n & reading;

  // link events into the core clock domain
  // each toggle moves at most once per register word, many core clocks apart,
  // so synchronising the two bits separately is safe
  csp_sync #(
    .W(2)
  ) u_evt_sync (
    .clock(clock),
    .rst_n(rst_n),
    .d(evt),
    .q(evt_s)
  );

  wire wr_evt = evt_s.wr_tgl ^ evt_d.wr_tgl;
  wire rd_evt = evt_s.rd_tgl ^ evt_d.rd_tgl;

  // edge detection on the synchronised toggles
  // reg_written_addr follows wr_hold every cycle; it is only meaningful
  // while reg_written is high, when wr_hold has long been stable
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      evt_d <= '0;
      reg_written <= 1'b0;
      reg_written_addr <= ADDR_STATUS;
      status_q <= 8'h80;
    end else begin
      evt_d <= evt_s;
      reg_written <= wr_evt;
      reg_written_addr <= wr_hold.addr;
      status_q <= {rdy_n, status_in};
    end
  end

  // data register and ready; a read leaves the word in place for rereads
  csp_ready u_ready (
    .clock(clock),
    .rst_n(rst_n),
    .conv_valid(conv_valid),
    .conv_data(conv_data),
    .rd_done(rd_evt),
    .data_reg(data_reg),
    .rdy_n(rdy_n)
  );

  // register file: status and data are read only, the rest are written
  // from the link; wr_hold is stable for many serial clocks after a toggle
  // writes to status and data are accepted on the link but dropped here
  for (genvar i = 0; i < NREG; i++) begin : g_reg
    if (i == int'(ADDR_STATUS)) begin : g_status
      assign reg_flat[i] = {16'h0000, status_q};
    end else if (i == int'(ADDR_DATA)) begin : g_data
      assign reg_flat[i] = data_reg;
    end else begin : g_cfg
      logic [REG_W-1:0] cfg_q;
      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          cfg_q <= REG_RST_VAL;
        end else if (wr_evt && wr_hold.addr == 3'(i)) begin
          cfg_q <= wr_hold.data;
        end
      end
      assign reg_flat[i] = cfg_q;
    end
    assign reg_image[i*REG_W +: REG_W] = reg_flat[i];
  end

endmodule

/* File: core/csp_pkg.sv */
// shared constants, types and helpers for the converter serial port
// assumes a 40 MHz core clock and a serial clock supplied by the host
package csp_pkg;

  // core clock rate and update guard before a data register refresh
  localparam int CLK_MHZ = 40;
  localparam int UPD_GUARD_NS = 100;
  localparam int UPD_GUARD_CYC = (UPD_GUARD_NS * CLK_MHZ + 999) / 1000;
  localparam logic [2:0] UPD_GUARD_LAST = 3'(UPD_GUARD_CYC - 1);

  // register file geometry
  localparam int NREG = 8;
  localparam int REG_W = 24;
  localparam int ADDR_W = 3;

  // register addresses carried in the communications byte
  localparam logic [2:0] ADDR_STATUS = 3'h0;
  localparam logic [2:0] ADDR_DATA = 3'h1;
  localparam logic [2:0] ADDR_MODE = 3'h2;
  localparam logic [2:0] ADDR_FILTER = 3'h3;
  localparam logic [2:0] ADDR_DAC = 3'h4;
  localparam logic [2:0] ADDR_OFFSET = 3'h5;
  localparam logic [2:0] ADDR_GAIN = 3'h6;
  localparam logic [2:0] ADDR_TEST = 3'h7;

  // communications byte fields
  localparam int COMM_RW_HI_POS = 5;
  localparam int COMM_RW_LO_POS = 4;
  localparam int COMM_ADDR_LSB = 0;

  // access type codes {access_type_hi, access_type_lo}
  localparam logic [1:0] ACC_WRITE = 2'h0;
  localparam logic [1:0] ACC_READ = 2'h1;
  localparam logic [1:0] ACC_CONT = 2'h2;
  localparam logic [1:0] ACC_EXIT = 2'h3;

  // transfer lengths in serial clocks
  localparam logic [4:0] LEN_8 = 5'h08;
  localparam logic [4:0] LEN_16 = 5'h10;
  localparam logic [4:0] LEN_24 = 5'h18;
  localparam logic [4:0] COMM_LEN = LEN_8;
  localparam logic [4:0] MSB_IDX = 5'h17;

  // values after reset
  localparam logic [23:0] REG_RST_VAL = 24'h000000;
  localparam logic [4:0] CNT_RST_VAL = 5'h00;

  typedef enum {ST_COMM, ST_WRITE, ST_READ, ST_CONT} csp_state_t;
  typedef enum {UPD_IDLE, UPD_GUARD} csp_upd_t;

  // one completed register write, handed from the link to the core
  typedef struct packed {
    logic [2:0] addr;
    logic [23:0] data;
  } csp_wr_t;

  // event toggles crossing from the link to the core
  typedef struct packed {
    logic rd_tgl;
    logic wr_tgl;
  } csp_evt_t;

  // length of each register in bits
  function automatic logic [4:0] csp_reg_len(input logic [2:0] addr);
    case (addr)
      ADDR_STATUS: csp_reg_len = LEN_8;
      ADDR_MODE: csp_reg_len = LEN_16;
      ADDR_DAC: csp_reg_len = LEN_8;
      default: csp_reg_len = LEN_24;
    endcase
  endfunction

  // mask keeping the low len bits of a word
  function automatic logic [23:0] csp_len_mask(input logic [4:0] len);
    csp_len_mask = ~(24'hFFFFFF << len);
  endfunction

endpackage

/* File: core/csp_sync.sv */
// two flip-flop level synchroniser, one bit per lane
// assumes each lane is a slowly changing level or toggle from another domain
`timescale 1ns/1ps
module csp_sync #(
  parameter int W = 2
) (
  // core clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // levels in and out
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;

  // first stage is read by the second stage only
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule

/* File: core/csp_ready.sv */
// data register and data-ready sequencer of the converter serial port
// assumes conv_valid and rd_done are one-cycle pulses on the core clock
`timescale 1ns/1ps
module csp_ready
  import csp_pkg::*;
(
  // core clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // new conversion word from the converter
  input wire logic conv_valid,
  input wire logic [23:0] conv_data,
  // completed read of the data register
  input wire logic rd_done,
  // data register and active-low ready
  output logic [23:0] data_reg,
  output logic rdy_n
);
  csp_upd_t ust;
  logic [23:0] pend;
  logic [2:0] gcnt;
  wire guard_end = (gcnt == 3'h0);

  // ready drops high a guard time before the refresh so a read never
  // copies a half-updated word; a fresh update beats a read completion
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ust <= UPD_IDLE;
      pend <= REG_RST_VAL;
      data_reg <= REG_RST_VAL;
      gcnt <= 3'h0;
      rdy_n <= 1'b1;
    end else begin
      case (ust)
        UPD_IDLE: begin
          if (conv_valid) begin
            pend <= conv_data;
            gcnt <= UPD_GUARD_LAST;
            rdy_n <= 1'b1;
            ust <= UPD_GUARD;
          end else if (rd_done) begin
            rdy_n <= 1'b1;
          end
        end
        UPD_GUARD: begin
          if (conv_valid) begin
            pend <= conv_data;
          end
          if (guard_end) begin
            data_reg <= conv_valid ? conv_data : pend;
            rdy_n <= 1'b0;
            ust <= UPD_IDLE;
          end else begin
            gcnt <= gcnt - 3'h1;
          end
        end
        default: ust <= UPD_IDLE;
      endcase
    end
  end
endmodule

/* File: test/csp_port_properties.sv */
// checker for the converter serial port on the core clock
// assumes it is bound to csp_port and sees only its ports
`timescale 1ns/1ps
module csp_port_properties
  import csp_pkg::*;
(
  // core clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // link side
  input wire logic cs_n,
  input wire logic dout_oe,
  input wire logic rdy_n,
  // converter side
  input wire logic conv_valid,
  input wire logic [23:0] conv_data,
  input wire logic [NREG*REG_W-1:0] reg_image,
  input wire logic reg_written,
  input wire logic [2:0] reg_written_addr
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);

  // a word taken, then a quiet guard of four clocks
  sequence s_settle;
    conv_valid ##1 (!conv_valid) [*4];
  endsequence

  a_oe_needs_cs: assert property (cs_n |-> !dout_oe)
    else $error("dout driven while deselected");
  a_rdy_after_reset: assert property ($rose(rst_n) |-> rdy_n)
    else $error("ready low right after reset");
  a_idle_after_reset: assert property ($rose(rst_n) |-> !dout_oe)
    else $error("port not idle after reset");
  a_guard_high: assert property (conv_valid |=> rdy_n [*4])
    else $error("ready low during update guard");
  a_new_word: assert property (s_settle |=> !rdy_n)
    else $error("ready not low after update");
  a_word_lands: assert property (s_settle |=> reg_image[47:24] == $past(conv_data, 5))
    else $error("data register not refreshed");
  a_data_source: assert property ($changed(reg_image[47:24]) |-> $past(conv_valid, 5))
    else $error("data register changed without a word");
  a_mode_update: assert property ($changed(reg_image[71:48]) |->
    reg_written && reg_written_addr == ADDR_MODE)
    else $error("mode changed without full write");
  a_dac_update: assert property ($changed(reg_image[119:96]) |->
    reg_written && reg_written_addr == ADDR_DAC)
    else $error("dac changed without full write");
  a_written_pulse: assert property (reg_written |=> !reg_written)
    else $error("write pulse longer than one clock");
endmodule

bind csp_port csp_port_properties i_props (.clock, .rst_n, .cs_n, .dout_oe, .rdy_n,
  .conv_valid, .conv_data, .reg_image, .reg_written, .reg_written_addr);

/* File: test/csp_host.sv */
// host serial master model: frames each transfer with cs_n, msb first
// assumes a static strap; link clock 80 ns, still between frames
`timescale 1ns/1ps
module csp_host (
  // strap and return path
  input wire logic edge_polarity_strap,
  input wire logic dout,
  input wire logic dout_oe,
  // link drive
  output logic sclk,
  output logic cs_n,
  output logic din
);
  // deselected link at time zero
  initial begin
    sclk = 1'b1;
    cs_n = 1'b1;
    din = 1'b0;
  end

  // one framed transfer of n bits
  task automatic xfer(input int n, input logic [23:0] wv, output logic [23:0] rv);
    rv = 24'h000000;
    sclk = edge_polarity_strap; // idle level
    #20 cs_n = 1'b0; // well ahead of the first launch
    for (int i = n - 1; i >= 0; i--) begin
      #40 sclk = ~sclk;
      din = wv[i]; // set up before its capture edge
      #40 rv[i] = dout_oe ? dout : 1'bx; // undriven line reads unknown
      sclk = ~sclk;
    end
    #40 cs_n = 1'b1;
    din = ~din; // released line shows no stale bit
  endtask
endmodule

/* File: test/csp_port_test.sv */
// self-checking bench for the converter serial port, both strap levels
// assumes csp_host masters the link; core clock 25 ns
`timescale 1ns/1ps
module csp_port_test
  import csp_pkg::*;
;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic edge_polarity_strap = 1'b1;
  logic conv_valid = 1'b0;
  logic [23:0] conv_data = 24'h000000;
  logic [6:0] status_in = 7'h00;
  wire sclk, cs_n, din, dout, dout_oe, rdy_n, reg_written;
  wire [NREG*REG_W-1:0] reg_image;
  wire [2:0] reg_written_addr;
  int miscompares = 0;
  int checks = 0;
  csp_wr_t exp_q[$];

  csp_port i_dut (.clock, .rst_n, .sclk, .cs_n, .din, .dout, .dout_oe, .rdy_n,
    .edge_polarity_strap, .conv_valid, .conv_data, .status_in, .reg_image,
    .reg_written, .reg_written_addr);
  csp_host i_host (.edge_polarity_strap, .dout, .dout_oe, .sclk, .cs_n, .din);

  // core clock
  initial begin
    forever #12.5 clock = ~clock;
  end

  task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic final_report();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  function automatic int reg_bits(input logic [2:0] a);
    return (a == ADDR_STATUS || a == ADDR_DAC) ? 8 : (a == ADDR_MODE) ? 16 : 24;
  endfunction

  task automatic rd(input logic [2:0] a, input logic [23:0] exp, input string what);
    logic [23:0] rv;
    i_host.xfer(8, {16'h0, 2'b00, ACC_READ, 1'b0, a}, rv);
    i_host.xfer(reg_bits(a), 24'h000000, rv);
    check(what, rv, exp);
  endtask

  task automatic wr(input logic [2:0] a, input logic [23:0] d);
    logic [23:0] rv;
    exp_q.push_back({a, d});
    i_host.xfer(8, {16'h0, 2'b00, ACC_WRITE, 1'b0, a}, rv);
    i_host.xfer(reg_bits(a), d, rv);
  endtask

  // bounded wait for a ready level; a hang closes the run
  task automatic wait_rdy(input logic v);
    for (int i = 0; i < 400 && rdy_n !== v; i++) begin
      @(posedge clock);
      #1;
    end
    check("rdy_n", {23'h0, rdy_n}, {23'h0, v});
    if (rdy_n !== v) final_report();
  endtask

  task automatic reset_dut(input logic s);
    @(posedge clock);
    #1 rst_n = 1'b0;
    edge_polarity_strap = s;
    status_in = 7'($urandom);
    conv_valid = 1'b1; // must be ignored in reset
    repeat (6) @(posedge clock);
    #1 rst_n = 1'b1;
    conv_valid = 1'b0;
  endtask

  task automatic convert(input logic [23:0] w);
    @(posedge clock);
    #1 conv_data = w;
    conv_valid = 1'b1;
    @(posedge clock);
    #1 conv_valid = 1'b0;
  endtask

  // each landed write takes the oldest note; sampled mid-cycle, clear of the edge
  always @(negedge clock) begin
    if (rst_n === 1'b1 && reg_written === 1'b1) begin
      if (exp_q.size() == 0) begin
        check("unexpected write", 24'h000001, 24'h000000);
      end else begin
        check("wr_addr", {21'h0, reg_written_addr}, {21'h0, exp_q[0].addr});
        check("wr_data", reg_image[reg_written_addr*24 +: 24], exp_q[0].data);
        void'(exp_q.pop_front());
      end
    end
  end

  initial begin
    logic [23:0] w;
    logic [23:0] rv;
    void'($urandom(57));
    for (int s = 1; s >= 0; s--) begin
      reset_dut(s[0]);
      rd(ADDR_STATUS, {16'h0, 1'b1, status_in}, "status after reset");
      rd(ADDR_DATA, 24'h000000, "data after reset");
      rd(ADDR_TEST, 24'h000000, "test reg after reset");
      for (int a = 2; a < 8; a++) begin
        w = 24'($urandom) & ~(24'hFFFFFF << reg_bits(3'(a)));
        wr(3'(a), w);
        rd(3'(a), w, "config readback");
      end
      // filter write split over two frames, then surplus ones
      w = 24'($urandom);
      exp_q.push_back({ADDR_FILTER, w});
      i_host.xfer(8, {16'h0, 2'b00, ACC_WRITE, 1'b0, ADDR_FILTER}, rv);
      i_host.xfer(16, {8'h0, w[23:8]}, rv);
      i_host.xfer(8, {16'h0, w[7:0]}, rv);
      i_host.xfer(8, 24'h0000FF, rv);
      rd(ADDR_FILTER, w, "split filter");
      $display("config tests done, strap %0d", s);
      w = 24'($urandom);
      convert(w);
      wait_rdy(1'b0); // read only after the update
      rd(ADDR_STATUS, {16'h0, 1'b0, status_in}, "status ready");
      rd(ADDR_DATA, w, "data read");
      wait_rdy(1'b1);
      rd(ADDR_DATA, w, "data reread");
      // continuous read with din held low, left with code 11
      i_host.xfer(8, {16'h0, 2'b00, ACC_CONT, 1'b0, ADDR_DATA}, rv);
      repeat (2) begin
        i_host.xfer(24, 24'h000000, rv);
        check("continuous word", rv, w);
      end
      i_host.xfer(8, {16'h0, 2'b00, ACC_EXIT, 4'h0}, rv);
      w = 24'($urandom) & 24'h0000FF;
      wr(ADDR_DAC, w);
      rd(ADDR_DAC, w, "dac after exit");
      check("writes landed", 24'(exp_q.size()), 24'h000000);
      $display("data tests done, strap %0d", s);
    end
    final_report();
  end
endmodule
